/* File: src/ett_exposure_timer.sv */
`timescale 1ns/1ns
`include "ett_defs.svh"
module ett_exposure_timer
  import ett_pkg::*;
#(
  parameter logic        ALT_MODEL  = 1'b0,
  parameter logic [23:0] MAX_EXP_US = `ETT_MAX_US_10M
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  external_acq_trigger,
  input  wire logic        readout_busy,
  output logic             exposure_active,
  output logic             frame_start,
  output logic             irq
);
  typedef struct packed {
    ett_state_t  st;
    logic [6:0]  tick_cnt;
    logic        tick;
    logic [31:0] hold_cnt;
    logic [23:0] base_cnt;
    logic [11:0] mult_cnt;
    logic [23:0] total;
    logic [31:0] rate_cnt;
    logic [7:0]  ctrl;
    logic [31:0] holdoff;
    logic [11:0] mult;
    logic [23:0] tb;
    logic [23:0] auto_us;
    logic [31:0] rate_us;
    logic [2:0]  irq_st;
    logic [2:0]  irq_msk;
    logic        awrdy;
    logic        wrdy;
    logic        bvld;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvld;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        exp_o;
    logic        fs_o;
    logic        irq_o;
  } ett_regs_t;

  ett_regs_t   s_r;
  ett_regs_t   s_nxt;
  logic        arm_w;
  logic        disarm_w;
  logic        swtrig_w;
  logic        start_w;
  logic        end_w;
  logic        ovt_w;
  logic        acc_w;
  logic        trig_go;
  logic        hw_edge;
  logic        lvl_act;
  logic        hw_mode;
  logic        pw_mode;
  logic        auto_eff;
  logic        rate_ok;
  logic [31:0] wval;
  logic [31:0] rval;

  ett_trig_if tr ();

  ett_line_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .line_in (external_acq_trigger),
    .tr      (tr)
  );

  function automatic logic [31:0] ett_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Trigger qualification from the control word.
  always_comb begin
    hw_mode = s_r.ctrl[`ETT_C_GATE] & s_r.ctrl[`ETT_C_HWSRC];
    hw_edge = s_r.ctrl[`ETT_C_FALL] ? tr.fall[s_r.ctrl[`ETT_C_LINE]]
                                    : tr.rise[s_r.ctrl[`ETT_C_LINE]]; // R13
    lvl_act = s_r.ctrl[`ETT_C_FALL] ? ~tr.lvl[s_r.ctrl[`ETT_C_LINE]]
                                    : tr.lvl[s_r.ctrl[`ETT_C_LINE]];
    pw_mode = s_r.ctrl[`ETT_C_PW] & hw_mode;
    auto_eff = s_r.ctrl[`ETT_C_AUTO] & ~s_r.ctrl[`ETT_C_PW]; // R11
    rate_ok = ~s_r.ctrl[`ETT_C_RATE] | (s_r.rate_cnt == 32'h0); // R12
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.fs_o = 1'b0;
    s_nxt.tick = 1'b0;
    arm_w = 1'b0;
    disarm_w = 1'b0;
    swtrig_w = 1'b0;
    start_w = 1'b0;
    end_w = 1'b0;
    ovt_w = 1'b0;
    acc_w = 1'b0;
    rval = 32'h0;
    wval = ett_merge(32'h0, s_r.wdata, s_r.wstrb);

    if (s_r.tick_cnt == 7'(`ETT_TICK_CYC - 1)) begin
      s_nxt.tick_cnt = 7'h0;
      s_nxt.tick = 1'b1; // R18
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 7'h1;
    end

    // Write channel: address and data may arrive in either order.
    if (s_axi_awvalid && s_r.awrdy) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awrdy = 1'b0;
      s_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wrdy) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wrdy = 1'b0;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvld) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvld = 1'b1;
      s_nxt.bresp = `ETT_OKAY;
      if (s_r.waddr == `ETT_A_CTRL) begin
        wval = ett_merge({24'h0, s_r.ctrl}, s_r.wdata, s_r.wstrb);
        s_nxt.ctrl = wval[7:0];
      end else if (s_r.waddr == `ETT_A_CMD) begin
        arm_w = wval[`ETT_K_ARM];
        disarm_w = wval[`ETT_K_DISARM];
        swtrig_w = wval[`ETT_K_SWTRIG];
      end else if (s_r.waddr == `ETT_A_HOLDOFF) begin
        s_nxt.holdoff = ett_merge(s_r.holdoff, s_r.wdata, s_r.wstrb);
      end else if (s_r.waddr == `ETT_A_MULT) begin
        wval = ett_merge({20'h0, s_r.mult}, s_r.wdata, s_r.wstrb);
        if (wval[31:12] == 20'h0 && wval[11:0] != 12'h0) begin
          s_nxt.mult = wval[11:0]; // R4
        end
      end else if (s_r.waddr == `ETT_A_TBASE) begin
        wval = ett_merge({8'h0, s_r.tb}, s_r.wdata, s_r.wstrb);
        if (wval[31:24] == 8'h0 && wval[23:0] != 24'h0) begin
          s_nxt.tb = wval[23:0]; // R8 R9
        end
      end else if (s_r.waddr == `ETT_A_AUTO) begin
        wval = ett_merge({8'h0, s_r.auto_us}, s_r.wdata, s_r.wstrb);
        if (wval[31:24] == 8'h0 && wval[23:0] != 24'h0) begin
          s_nxt.auto_us = wval[23:0]; // R10
        end
      end else if (s_r.waddr == `ETT_A_STATUS) begin
        s_nxt.bresp = `ETT_OKAY;
      end else if (s_r.waddr == `ETT_A_IRQ_STAT) begin
        s_nxt.irq_st = s_r.irq_st & ~wval[2:0];
      end else if (s_r.waddr == `ETT_A_IRQ_MASK) begin
        wval = ett_merge({29'h0, s_r.irq_msk}, s_r.wdata, s_r.wstrb);
        s_nxt.irq_msk = wval[2:0];
      end else if (s_r.waddr == `ETT_A_RATE) begin
        s_nxt.rate_us = ett_merge(s_r.rate_us, s_r.wdata, s_r.wstrb);
      end else begin
        s_nxt.bresp = `ETT_SLVERR;
      end
    end
    if (s_r.bvld && s_axi_bready) begin
      s_nxt.bvld = 1'b0;
      s_nxt.awrdy = 1'b1;
      s_nxt.wrdy = 1'b1;
    end

    // Read channel.
    if (s_axi_araddr == `ETT_A_CTRL) begin
      rval = {24'h0, s_r.ctrl};
    end else if (s_axi_araddr == `ETT_A_HOLDOFF) begin
      rval = s_r.holdoff;
    end else if (s_axi_araddr == `ETT_A_MULT) begin
      rval = {20'h0, s_r.mult};
    end else if (s_axi_araddr == `ETT_A_TBASE) begin
      rval = {8'h0, s_r.tb};
    end else if (s_axi_araddr == `ETT_A_AUTO) begin
      rval = {8'h0, s_r.auto_us};
    end else if (s_axi_araddr == `ETT_A_STATUS) begin
      rval = {26'h0, lvl_act, readout_busy, auto_eff, s_r.exp_o, s_r.st};
    end else if (s_axi_araddr == `ETT_A_IRQ_STAT) begin
      rval = {29'h0, s_r.irq_st};
    end else if (s_axi_araddr == `ETT_A_IRQ_MASK) begin
      rval = {29'h0, s_r.irq_msk};
    end else if (s_axi_araddr == `ETT_A_RATE) begin
      rval = s_r.rate_us;
    end else begin
      rval = 32'h0;
    end
    if (s_axi_arvalid && s_r.arrdy) begin
      s_nxt.arrdy = 1'b0;
      s_nxt.rvld = 1'b1;
      s_nxt.rdata = rval;
      s_nxt.rresp = (s_axi_araddr == `ETT_A_CMD || s_axi_araddr > `ETT_A_RATE ||
                     s_axi_araddr[1:0] != 2'h0) ? `ETT_SLVERR : `ETT_OKAY;
    end
    if (s_r.rvld && s_axi_rready) begin
      s_nxt.rvld = 1'b0;
      s_nxt.arrdy = 1'b1;
    end

    // Trigger source: hardware edge, software command, or none.
    if (hw_mode) begin
      trig_go = hw_edge;
    end else begin
      trig_go = s_r.ctrl[`ETT_C_GATE] & swtrig_w;
    end

    if (s_r.tick && s_r.rate_cnt != 32'h0) begin
      s_nxt.rate_cnt = s_r.rate_cnt - 32'h1;
    end

    case (s_r.st)
      ETT_IDLE: begin
        if (arm_w) begin
          s_nxt.st = ETT_WAIT;
        end
      end
      ETT_WAIT: begin
        if ((trig_go || !s_r.ctrl[`ETT_C_GATE]) && rate_ok) begin
          acc_w = s_r.ctrl[`ETT_C_GATE];
          if (hw_mode && s_r.holdoff != 32'h0) begin
            s_nxt.st = ETT_HOLD; // R1
            s_nxt.hold_cnt = 32'h0;
          end else begin
            start_w = 1'b1; // R2
          end
        end else if (trig_go) begin
          ovt_w = 1'b1;
        end
      end
      ETT_HOLD: begin
        ovt_w = trig_go;
        // The first tick may come at once, so one extra tick keeps the full hold-off.
        if (s_r.tick) begin
          if (s_r.hold_cnt >= s_r.holdoff) begin
            start_w = 1'b1; // R1
          end else begin
            s_nxt.hold_cnt = s_r.hold_cnt + 32'h1;
          end
        end
      end
      ETT_EXP: begin
        ovt_w = trig_go; // R15
        if (pw_mode) begin
          end_w = ~lvl_act & ~readout_busy; // R16 R17
        end
        if (s_r.tick) begin
          s_nxt.total = s_r.total + 24'h1;
          if (s_r.total + 24'h1 >= MAX_EXP_US) begin
            end_w = 1'b1; // R7
          end
          if (pw_mode) begin
            s_nxt.base_cnt = 24'h0;
          end else if (auto_eff) begin
            if (s_r.total + 24'h1 >= s_r.auto_us) begin
              end_w = 1'b1; // R10
            end
          end else if (s_r.base_cnt + 24'h1 >= s_r.tb) begin
            s_nxt.base_cnt = 24'h0;
            s_nxt.mult_cnt = s_r.mult_cnt + 12'h1;
            if (s_r.mult_cnt + 12'h1 >= s_r.mult) begin
              end_w = 1'b1; // R3
            end
          end else begin
            s_nxt.base_cnt = s_r.base_cnt + 24'h1;
          end
        end
      end
      default: begin
        s_nxt.st = ETT_IDLE;
      end
    endcase

    if (start_w) begin
      s_nxt.st = ETT_EXP;
      s_nxt.exp_o = 1'b1;
      s_nxt.fs_o = 1'b1;
      s_nxt.base_cnt = 24'h0;
      s_nxt.mult_cnt = 12'h0;
      s_nxt.total = 24'h0;
      s_nxt.rate_cnt = s_r.rate_us;
    end
    if (end_w) begin
      s_nxt.st = ETT_WAIT;
      s_nxt.exp_o = 1'b0;
    end
    if (disarm_w) begin
      s_nxt.st = ETT_IDLE;
      s_nxt.exp_o = 1'b0;
      s_nxt.fs_o = 1'b0;
    end

    // Events set after the software clear so a same-cycle event survives.
    if (ovt_w) begin
      s_nxt.irq_st[`ETT_I_OVT] = 1'b1;
    end
    if (end_w) begin
      s_nxt.irq_st[`ETT_I_END] = 1'b1;
    end
    if (acc_w) begin
      s_nxt.irq_st[`ETT_I_ACC] = 1'b1;
    end
    s_nxt.irq_o = |(s_nxt.irq_st & s_nxt.irq_msk);

    if (!aresetn) begin
      s_nxt = '0;
      s_nxt.st = ETT_IDLE;
      s_nxt.awrdy = 1'b1;
      s_nxt.wrdy = 1'b1;
      s_nxt.arrdy = 1'b1;
      s_nxt.mult = `ETT_MULT_RST;
      s_nxt.auto_us = `ETT_AUTO_RST;
      s_nxt.tb = ALT_MODEL ? `ETT_TB_RST_ALT : `ETT_TB_RST; // R5
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  assign s_axi_awready = s_r.awrdy;
  assign s_axi_wready = s_r.wrdy;
  assign s_axi_bvalid = s_r.bvld;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arrdy;
  assign s_axi_rvalid = s_r.rvld;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;
  assign exposure_active = s_r.exp_o;
  assign frame_start = s_r.fs_o;
  assign irq = s_r.irq_o;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hold_waits: assert property ( // R1
    (s_r.st == ETT_HOLD && s_r.hold_cnt < s_r.holdoff && !disarm_w)
      |=> s_r.st == ETT_HOLD && !exposure_active)
    else $error("hold-off ended early");
  a_sw_nodelay: assert property ( // R2
    (s_r.st == ETT_WAIT && !hw_mode && trig_go && rate_ok && !disarm_w)
      |=> s_r.st == ETT_EXP && frame_start)
    else $error("software trigger was delayed");
  a_timed_end: assert property ( // R3
    (s_r.st == ETT_EXP && !pw_mode && !auto_eff && s_r.tick && !disarm_w &&
     s_r.base_cnt + 24'h1 < s_r.tb && s_r.total + 24'h1 < MAX_EXP_US)
      |=> s_r.st == ETT_EXP)
    else $error("timed exposure ended inside a base period");
  a_mult_range: assert property (s_r.mult != 12'h0) // R4
    else $error("multiplier left its range");
  a_base_reset: assert property ( // R5
    $past(!aresetn) |-> s_r.tb == (ALT_MODEL ? `ETT_TB_RST_ALT : `ETT_TB_RST))
    else $error("time base reset value wrong");
  a_exp_ceiling: assert property (s_r.total <= MAX_EXP_US) // R7
    else $error("exposure passed the ceiling");
  a_auto_off: assert property (s_r.ctrl[`ETT_C_PW] |-> !auto_eff) // R11
    else $error("automatic exposure active in pulse-width mode");
  a_ovt_flag: assert property ( // R15
    (s_r.st == ETT_EXP && trig_go) |=> s_r.irq_st[`ETT_I_OVT] && !frame_start)
    else $error("overtrigger not flagged");
  a_pw_stretch: assert property ( // R16 R17
    (s_r.st == ETT_EXP && pw_mode && (lvl_act || readout_busy) && !disarm_w &&
     !(s_r.tick && s_r.total + 24'h1 >= MAX_EXP_US)) |=> exposure_active)
    else $error("pulse-width exposure ended too soon");
  a_tick_rate: assert property ( // R18
    s_r.tick |=> !s_r.tick [*8])
    else $error("microsecond tick too fast");
endmodule

/* File: src/ett_defs.svh */
`ifndef ETT_DEFS_SVH
`define ETT_DEFS_SVH
// What this block does
// [R1] A hardware trigger waits the programmed hold-off in microseconds before acting.
// [R2] Software triggers and switched-off triggering take no hold-off.
// [R3] Timed exposure lasts the multiplier times the time base.
// [R4] The multiplier accepts values 1 through 4095 only.
// [R5] The time base resets to 20 us, or 31 us on the alternate model.
// [R6] Software must not program an exposure below the model minimum.
// [R7] Exposure is capped at the model ceiling.
// [R8] Multiplier 1 with a 10000000 us base gives the longest exposure.
// [R9] The small-ceiling model reaches its maximum with 2048 times 62 us.
// [R10] Automatic exposure may use any whole microsecond length.
// [R11] Pulse-width mode switches automatic exposure off.
// [R12] With the rate limit off, triggers alone pace acquisition.
// [R13] Rising-edge mode starts acquisition when the chosen line goes high.
// [R14] Software arms before triggers count and disarms to stop.
// [R15] A trigger during an exposure is ignored and flags an overtrigger.
// [R16] Pulse-width mode exposes from the active edge to the opposite edge.
// [R17] A pulse ending during readout stretches exposure to readout end.
// [R18] A one-microsecond tick paces hold-off and exposure counters.

`define ETT_CLK_NS      10
`define ETT_TICK_NS     1000
`define ETT_TICK_CYC    (`ETT_TICK_NS / `ETT_CLK_NS)

`define ETT_A_CTRL      8'h00
`define ETT_A_CMD       8'h04
`define ETT_A_HOLDOFF   8'h08
`define ETT_A_MULT      8'h0c
`define ETT_A_TBASE     8'h10
`define ETT_A_AUTO      8'h14
`define ETT_A_STATUS    8'h18
`define ETT_A_IRQ_STAT  8'h1c
`define ETT_A_IRQ_MASK  8'h20
`define ETT_A_RATE      8'h24

`define ETT_C_GATE      0
`define ETT_C_HWSRC     1
`define ETT_C_FALL      2
`define ETT_C_LINE      3
`define ETT_C_PW        4
`define ETT_C_AUTO      5
`define ETT_C_RATE      6

`define ETT_K_ARM       0
`define ETT_K_DISARM    1
`define ETT_K_SWTRIG    2

`define ETT_I_OVT       0
`define ETT_I_END       1
`define ETT_I_ACC       2

`define ETT_MULT_RST    12'h064
`define ETT_TB_RST      24'h000014
`define ETT_TB_RST_ALT  24'h00001f
`define ETT_MAX_US_10M  24'h989680
`define ETT_MAX_US_1M   24'h0f4240
`define ETT_MAX_US_SML  24'h01f000
`define ETT_AUTO_RST    24'h0007d0

`define ETT_OKAY        2'b00
`define ETT_SLVERR      2'b10
`endif

/* File: src/ett_pkg.sv */
package ett_pkg;
  typedef enum logic [1:0] {ETT_IDLE, ETT_WAIT, ETT_HOLD, ETT_EXP} ett_state_t;
endpackage

/* File: src/ett_trig_if.sv */
`timescale 1ns/1ns
interface ett_trig_if;
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

/* File: src/ett_line_sync.sv */
`timescale 1ns/1ns
module ett_line_sync
  import ett_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] line_in,
  ett_trig_if.src         tr
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] q;
    logic [1:0] rise;
    logic [1:0] fall;
  } ett_sync_t;

  ett_sync_t s_r;
  ett_sync_t s_nxt;

  // A level change is taken only once the second and third stages agree.
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = line_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.rise = 2'h0;
    s_nxt.fall = 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (s_r.s2[i] == s_r.s3[i] && s_r.s3[i] != s_r.q[i]) begin
        s_nxt.q[i] = s_r.s3[i];
        s_nxt.rise[i] = s_r.s3[i];
        s_nxt.fall[i] = ~s_r.s3[i];
      end
    end
    if (!aresetn) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  assign tr.lvl = s_r.q;
  assign tr.rise = s_r.rise;
  assign tr.fall = s_r.fall;
endmodule

/* File: dv/ett_trig_src.sv */
`timescale 1ns/1ns
module ett_trig_src (
  input  wire logic  aclk,
  output logic [1:0] external_acq_trigger,
  output logic       readout_busy
);
  initial begin
    external_acq_trigger = 2'b00;
    readout_busy = 1'b0;
  end
  // The source moves just after a clock edge, with no relation to the tick phase.
  task automatic set_line(input int idx, input logic v);
    @(posedge aclk);
    external_acq_trigger[idx] <= v;
  endtask
  task automatic set_busy(input logic v);
    @(posedge aclk);
    readout_busy <= v;
  endtask
endmodule

/* File: dv/exposure_trigger_timer_tb_top.sv */
`timescale 1ns/1ns
`include "ett_defs.svh"
module exposure_trigger_timer_tb_top import ett_pkg::*;;
  localparam int          TCK = `ETT_TICK_CYC;
  localparam logic [31:0] HW  = (32'h1 << `ETT_C_GATE) | (32'h1 << `ETT_C_HWSRC);
  localparam logic [31:0] PW  = 32'h1 << `ETT_C_PW;
  localparam logic [31:0] AU  = 32'h1 << `ETT_C_AUTO;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [1:0]  external_acq_trigger;
  logic        readout_busy;
  logic        exposure_active;
  logic        frame_start;
  logic        irq;
  int          n_errors;
  int          n_checks;
  int          n_fs;
  ett_exposure_timer #(.ALT_MODEL(1'b0), .MAX_EXP_US(24'h000018)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_acq_trigger,
    .readout_busy, .exposure_active, .frame_start, .irq);
  ett_trig_src u_src (.aclk, .external_acq_trigger, .readout_busy);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (frame_start === 1'b1) n_fs++;
  task close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task tmo;
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (i == 100) tmo();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (i == 100) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic setup(input logic [31:0] c, input logic [31:0] m, input logic [31:0] h);
    logic [1:0] r;
    wr(`ETT_A_CMD, 32'h1 << `ETT_K_DISARM, r);
    wr(`ETT_A_CTRL, c, r);
    wr(`ETT_A_MULT, m, r);
    wr(`ETT_A_TBASE, 32'h1, r);
    wr(`ETT_A_HOLDOFF, h, r);
    wr(`ETT_A_CMD, 32'h1 << `ETT_K_ARM, r);
  endtask
  task automatic exp_len(output int w, output int len);
    for (w = 0; w < 4000 && exposure_active !== 1'b1; w++) @(posedge aclk);
    if (w == 4000) tmo();
    for (len = 0; len < 5000 && exposure_active === 1'b1; len++) @(posedge aclk);
    if (len == 5000) tmo();
  endtask
  function automatic logic in_n(int len, int n);
    return len > (n - 1) * TCK && len <= n * TCK + 1;
  endfunction
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`ETT_A_CTRL, d, r);
    chk(d === 32'h0 && r === `ETT_OKAY, "control reset value");
    rd(`ETT_A_TBASE, d, r);
    chk(d === 32'h14, "time base reset value");
    wr(`ETT_A_MULT, 32'h0, r);
    rd(`ETT_A_MULT, d, r);
    chk(d === 32'h64, "multiplier zero taken");
    wr(`ETT_A_MULT, 32'hfff, r);
    rd(`ETT_A_MULT, d, r);
    chk(d === 32'hfff, "multiplier top refused");
    wr(`ETT_A_MULT, 32'h1000, r);
    rd(`ETT_A_MULT, d, r);
    chk(d === 32'hfff, "multiplier overflow taken");
    wr(8'h40, 32'h1, r);
    chk(r === `ETT_SLVERR, "unmapped write response");
    rd(8'h40, d, r);
    chk(d === 32'h0 && r === `ETT_SLVERR, "unmapped read response");
    $display("test regs done");
  endtask
  task automatic t_timed;
    int w;
    int len;
    int f0;
    logic [1:0] r;
    setup(HW, 32'h10, 32'h0);
    f0 = n_fs;
    u_src.set_line(0, 1'b1);
    exp_len(w, len);
    chk(w < 12, "rising edge start late");
    chk(in_n(len, 16), "timed exposure length");
    u_src.set_line(0, 1'b0);
    repeat (10) @(posedge aclk);
    u_src.set_line(0, 1'b1);
    exp_len(w, len);
    chk(n_fs - f0 === 2, "trigger pacing refused");
    u_src.set_line(0, 1'b0);
    setup(HW | (32'h1 << `ETT_C_RATE), 32'h10, 32'h0);
    wr(`ETT_A_RATE, 32'h28, r);
    f0 = n_fs;
    u_src.set_line(0, 1'b1);
    exp_len(w, len);
    u_src.set_line(0, 1'b0);
    repeat (10) @(posedge aclk);
    u_src.set_line(0, 1'b1);
    repeat (20) @(posedge aclk);
    chk(n_fs - f0 === 1, "rate limit let a trigger through");
    u_src.set_line(0, 1'b0);
    setup(HW | (32'h1 << `ETT_C_FALL) | (32'h1 << `ETT_C_LINE), 32'h10, 32'h0);
    u_src.set_line(1, 1'b1);
    repeat (10) @(posedge aclk);
    chk(exposure_active === 1'b0, "falling mode started on a rise");
    u_src.set_line(1, 1'b0);
    exp_len(w, len);
    chk(w < 12 && in_n(len, 16), "falling edge on line 1 wrong");
    $display("test timed done");
  endtask
  task automatic t_hold;
    int w;
    int len;
    logic [1:0] r;
    setup(HW, 32'h10, 32'h2);
    u_src.set_line(0, 1'b1);
    exp_len(w, len);
    chk(w >= 2 * TCK && w <= 3 * TCK + 12, "hold-off length");
    u_src.set_line(0, 1'b0);
    setup(32'h1 << `ETT_C_GATE, 32'h10, 32'h2);
    wr(`ETT_A_CMD, 32'h1 << `ETT_K_SWTRIG, r);
    exp_len(w, len);
    chk(w <= 5, "software trigger delayed");
    setup(32'h0, 32'h10, 32'h2);
    exp_len(w, len);
    chk(w <= 5, "gate off delayed");
    $display("test hold done");
  endtask
  task automatic t_ovt;
    int w;
    int len;
    int f0;
    logic [31:0] d;
    logic [1:0]  r;
    wr(`ETT_A_IRQ_MASK, 32'h0, r);
    setup(HW, 32'h10, 32'h0);
    wr(`ETT_A_IRQ_STAT, 32'h7, r);
    f0 = n_fs;
    fork
      exp_len(w, len);
      begin
        u_src.set_line(0, 1'b1);
        repeat (200) @(posedge aclk);
        u_src.set_line(0, 1'b0);
        repeat (200) @(posedge aclk);
        u_src.set_line(0, 1'b1);
      end
    join
    chk(n_fs - f0 === 1 && in_n(len, 16), "overtrigger restarted");
    u_src.set_line(0, 1'b0);
    rd(`ETT_A_IRQ_STAT, d, r);
    chk(d[`ETT_I_OVT] === 1'b1, "overtrigger event missing");
    chk(irq === 1'b0, "masked interrupt raised");
    wr(`ETT_A_IRQ_MASK, 32'h1, r);
    repeat (3) @(posedge aclk);
    chk(irq === 1'b1, "unmasked interrupt low");
    wr(`ETT_A_IRQ_STAT, 32'h7, r);
    repeat (3) @(posedge aclk);
    chk(irq === 1'b0, "cleared interrupt high");
    $display("test ovt done");
  endtask
  task automatic t_pw;
    int w;
    int len;
    logic [31:0] d;
    logic [1:0]  r;
    setup(HW | PW, 32'h10, 32'h0);
    fork
      exp_len(w, len);
      begin
        u_src.set_line(0, 1'b1);
        repeat (300) @(posedge aclk);
        u_src.set_line(0, 1'b0);
      end
    join
    chk(len >= 294 && len <= 308, "pulse width length");
    fork
      exp_len(w, len);
      begin
        u_src.set_line(0, 1'b1);
        repeat (100) @(posedge aclk);
        u_src.set_busy(1'b1);
        repeat (200) @(posedge aclk);
        u_src.set_line(0, 1'b0);
        repeat (200) @(posedge aclk);
        u_src.set_busy(1'b0);
      end
    join
    chk(len >= 488 && len <= 506, "readout stretch length");
    wr(`ETT_A_CTRL, HW | PW | AU, r);
    rd(`ETT_A_STATUS, d, r);
    chk(d[3] === 1'b0, "auto kept in pulse mode");
    wr(`ETT_A_CTRL, HW | AU, r);
    rd(`ETT_A_STATUS, d, r);
    chk(d[3] === 1'b1, "auto missing outside pulse mode");
    $display("test pw done");
  endtask
  task automatic t_auto_cap;
    int w;
    int len;
    logic [1:0] r;
    setup(HW | AU, 32'h4, 32'h0);
    wr(`ETT_A_AUTO, 32'h17, r);
    u_src.set_line(0, 1'b1);
    exp_len(w, len);
    chk(in_n(len, 23), "auto exposure length");
    u_src.set_line(0, 1'b0);
    setup(HW, 32'hfff, 32'h0);
    u_src.set_line(0, 1'b1);
    exp_len(w, len);
    chk(in_n(len, 24), "exposure ceiling");
    u_src.set_line(0, 1'b0);
    $display("test auto_cap done");
  endtask
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    t_regs();
    t_timed();
    t_hold();
    t_ovt();
    t_pw();
    t_auto_cap();
    close_out();
  end
endmodule
